// [hdl/tsq_pkg.sv]
// Package of the trace sequencer: register map, field layout, reset values and types.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.

package tsq_pkg;

	// ****************************************************************
	// Sizes.
	// ****************************************************************
	localparam int TERMS   = 8;
	localparam int TERM_W  = 3;
	localparam int STATE_W = 12;
	localparam int ADR_W   = 8;
	localparam int IRQ_W   = 2;

	// ****************************************************************
	// Register offsets.
	// ****************************************************************
	localparam logic [ADR_W-1:0] ADR_CTRL        = 8'h00;
	localparam logic [ADR_W-1:0] ADR_STATUS      = 8'h04;
	localparam logic [ADR_W-1:0] ADR_IRQ_STAT    = 8'h08;
	localparam logic [ADR_W-1:0] ADR_IRQ_MASK    = 8'h0C;
	localparam logic [ADR_W-1:0] ADR_TERM_SEL    = 8'h10;
	localparam logic [ADR_W-1:0] ADR_PRI_PAT     = 8'h14;
	localparam logic [ADR_W-1:0] ADR_SEC_PAT     = 8'h18;
	localparam logic [ADR_W-1:0] ADR_STO_PAT     = 8'h1C;
	localparam logic [ADR_W-1:0] ADR_TERM_DEST   = 8'h20;
	localparam logic [ADR_W-1:0] ADR_SIMPLE_TRIG = 8'h24;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int CTRL_FULL_BIT   = 0;
	localparam int CTRL_SEQRST_BIT = 1;
	localparam int CTRL_RUN_BIT    = 2;
	localparam int CTRL_LAST_LSB   = 8;
	localparam int CTRL_TRIG_LSB   = 12;
	localparam int STAT_TERM_LSB   = 0;
	localparam int STAT_TRIG_BIT   = 4;
	localparam int STAT_RUN_LSB    = 8;
	localparam int STAT_FULL_BIT   = 12;
	localparam int TSEL_ALL_BIT    = 8;
	localparam int DEST_PRI_LSB    = 0;
	localparam int DEST_SEC_LSB    = 8;
	localparam int PAT_EN_BIT      = 31;
	localparam int PAT_MASK_LSB    = 16;
	localparam int PAT_VAL_LSB     = 0;
	localparam int IRQ_TRIG_BIT    = 0;
	localparam int IRQ_RESTART_BIT = 1;

	// ****************************************************************
	// Reset values.
	// ****************************************************************
	localparam logic [31:0]       PAT_ANY       = 32'h8000_0000;
	localparam logic [31:0]       PAT_NEVER     = 32'h0000_0000;
	localparam logic [TERM_W-1:0] TRIG_TERM_RST = 3'h1;
	localparam logic [TERM_W-1:0] FIRST_TERM    = 3'h0;
	localparam logic [TERM_W-1:0] LAST_TERM     = 3'h7;
	localparam logic [TERM_W-1:0] SIMPLE_LAST_RST = 3'h0;

	// ****************************************************************
	// Types.
	// ****************************************************************
	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_RUN  = 2'b01,
		SQ_DONE = 2'b11
	} tsq_run_t;

endpackage

// [hdl/tsq_eval_if.sv]
// Interface between the sequencer core and the term expression evaluator.
// Assumes both ends run on the sequencer clock.
`timescale 1ns/100ps

interface tsq_eval_if;
	logic [tsq_pkg::STATE_W-1:0] state;
	logic [31:0]                 pri_pat;
	logic [31:0]                 sec_pat;
	logic [31:0]                 sto_pat;
	logic                        pri_hit;
	logic                        sec_hit;
	logic                        sto_hit;

	modport ctl  (output state, output pri_pat, output sec_pat, output sto_pat,
	              input pri_hit, input sec_hit, input sto_hit);
	modport eval (input state, input pri_pat, input sec_pat, input sto_pat,
	              output pri_hit, output sec_hit, output sto_hit);
endinterface // tsq_eval_if

// [hdl/tsq_term_eval.sv]
// Evaluator of the current term's primary, secondary and storage expressions; in simple mode the secondary and storage ones come from term 0.
// Assumes patterns hold enable, mask and value fields; the state is one captured bus state.
`timescale 1ns/100ps

module tsq_term_eval (
	tsq_eval_if.eval ev
);

	// ****************************************************************
	// Pattern match.
	// ****************************************************************
	function automatic logic pat_match(input logic [31:0]                 pat,
	                                   input logic [tsq_pkg::STATE_W-1:0] st);
		logic [tsq_pkg::STATE_W-1:0] val;
		logic [tsq_pkg::STATE_W-1:0] msk;
		val = pat[tsq_pkg::PAT_VAL_LSB +: tsq_pkg::STATE_W];
		msk = pat[tsq_pkg::PAT_MASK_LSB +: tsq_pkg::STATE_W];
		pat_match = pat[tsq_pkg::PAT_EN_BIT] & (((st ^ val) & msk) == '0);
	endfunction

	assign ev.pri_hit = pat_match(ev.pri_pat, ev.state);
	assign ev.sec_hit = pat_match(ev.sec_pat, ev.state);
	assign ev.sto_hit = pat_match(ev.sto_pat, ev.state);

endmodule // tsq_term_eval

// [hdl/tsq_sequencer.sv]
// Trigger and storage sequencer of a bus state analyzer, with a classic Wishbone slave.
// Assumes one captured state per clock when state_vld_i is high, synchronous to clk_sys_i.
//
// Behaviour
// - Simple primary match advances to next term.
// - Simple secondary match restarts at first term.
// - Simple mode uses one global storage qualifier.
// - Simple trigger loads term 1, trigger term 2.
// - Full primary branch goes to programmable term.
// - Full per-term secondary expression and destination.
// - Full per-term qualifier, settable on all at once.
// - Full mode has more terms, selectable destinations.
// - Entering full mode loads default specification.
// - Reset request in full mode restores defaults.
// - Full mode: eight terms; entering trigger term signals trigger.
// - Simple trigger on branch out of last term.
// - Defaults: primary any except last, never, store all.
// - Default trigger term is the second term.
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps

module tsq_sequencer #(
	parameter int SIMPLE_TERMS = 4
) (
	input  wire logic                        clk_sys_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [tsq_pkg::ADR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic                        state_vld_i,
	input  wire logic [tsq_pkg::STATE_W-1:0] state_i,
	output logic                             store_o,
	output logic      [tsq_pkg::STATE_W-1:0] store_state_o,
	output logic                             trig_o,
	output logic      [tsq_pkg::TERM_W-1:0]  term_o,
	output logic                             irq_o
);

	localparam int TW = tsq_pkg::TERM_W;
	localparam logic [TW-1:0] SIMPLE_MAX = TW'(SIMPLE_TERMS - 1);

	// ****************************************************************
	// Reset release.
	// ****************************************************************
	logic rst_meta_q;
	logic rst_sync_q;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ****************************************************************
	// Wishbone decode.
	// ****************************************************************
	logic            ack_q;
	logic [31:0]     dat_q;
	logic            full_q;
	logic            run_q;
	logic [TW-1:0]   simple_last_q;
	logic [TW-1:0]   trig_term_q;
	logic [TW-1:0]   tsel_q;
	logic            tsel_all_q;
	logic [31:0]     pri_pat_q [tsq_pkg::TERMS];
	logic [31:0]     sec_pat_q [tsq_pkg::TERMS];
	logic [31:0]     sto_pat_q [tsq_pkg::TERMS];
	logic [TW-1:0]   pri_dest_q [tsq_pkg::TERMS];
	logic [TW-1:0]   sec_dest_q [tsq_pkg::TERMS];
	logic [TW-1:0]   cur_q;
	tsq_pkg::tsq_run_t run_st_q;
	logic            triggered_q;
	logic [tsq_pkg::IRQ_W-1:0] irq_stat_q;
	logic [tsq_pkg::IRQ_W-1:0] irq_mask_q;

	wire        req      = wb_cyc_i & wb_stb_i;
	wire        wr       = req & wb_we_i & ack_q;
	wire [31:0] bmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] wd       = wb_dat_i & bmask;
	wire        ctrl_wr  = wr & (wb_adr_i == tsq_pkg::ADR_CTRL);
	wire        isr_wr   = wr & (wb_adr_i == tsq_pkg::ADR_IRQ_STAT);
	wire        imr_wr   = wr & (wb_adr_i == tsq_pkg::ADR_IRQ_MASK);
	wire        tsel_wr  = wr & (wb_adr_i == tsq_pkg::ADR_TERM_SEL);
	wire        pri_wr   = wr & (wb_adr_i == tsq_pkg::ADR_PRI_PAT);
	wire        sec_wr   = wr & (wb_adr_i == tsq_pkg::ADR_SEC_PAT);
	wire        sto_wr   = wr & (wb_adr_i == tsq_pkg::ADR_STO_PAT);
	wire        dest_wr  = wr & (wb_adr_i == tsq_pkg::ADR_TERM_DEST);
	wire        strig_wr = wr & (wb_adr_i == tsq_pkg::ADR_SIMPLE_TRIG);

	wire          wd_full   = wd[tsq_pkg::CTRL_FULL_BIT];
	wire          wd_seqrst = wd[tsq_pkg::CTRL_SEQRST_BIT];
	wire [TW-1:0] wd_last   = wd[tsq_pkg::CTRL_LAST_LSB +: TW];
	wire [TW-1:0] wd_trig   = wd[tsq_pkg::CTRL_TRIG_LSB +: TW];

	wire full_rise = ctrl_wr & wd_full & !full_q;
	wire mode_chg  = ctrl_wr & (wd_full != full_q);
	wire seq_rst   = ctrl_wr & wd_seqrst;
	wire spec_rst  = full_rise | (seq_rst & full_q & wd_full);
	wire restart   = seq_rst | mode_chg | strig_wr;

	// ****************************************************************
	// Read multiplexer.
	// ****************************************************************
	wire [31:0] stat_word = {19'h0, full_q, 2'h0, run_st_q, 3'h0, triggered_q, 1'b0, cur_q};
	wire [31:0] ctrl_word = {17'h0, trig_term_q, 1'b0, simple_last_q, 5'h0, run_q, 1'b0, full_q};
	wire [31:0] tsel_word = {23'h0, tsel_all_q, 5'h0, tsel_q};
	wire [31:0] dest_word = {21'h0, sec_dest_q[tsel_q], 5'h0, pri_dest_q[tsel_q]};
	wire [31:0] rd_data =
		(wb_adr_i == tsq_pkg::ADR_CTRL)      ? ctrl_word :
		(wb_adr_i == tsq_pkg::ADR_STATUS)    ? stat_word :
		(wb_adr_i == tsq_pkg::ADR_IRQ_STAT)  ? {30'h0, irq_stat_q} :
		(wb_adr_i == tsq_pkg::ADR_IRQ_MASK)  ? {30'h0, irq_mask_q} :
		(wb_adr_i == tsq_pkg::ADR_TERM_SEL)  ? tsel_word :
		(wb_adr_i == tsq_pkg::ADR_PRI_PAT)   ? pri_pat_q[tsel_q] :
		(wb_adr_i == tsq_pkg::ADR_SEC_PAT)   ? sec_pat_q[tsel_q] :
		(wb_adr_i == tsq_pkg::ADR_STO_PAT)   ? sto_pat_q[tsel_q] :
		(wb_adr_i == tsq_pkg::ADR_TERM_DEST) ? dest_word :
		32'h0000_0000;

	always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req & !ack_q;
			dat_q <= (req & !ack_q) ? rd_data : 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// ****************************************************************
	// Control registers.
	// ****************************************************************
	wire trig_ok = (wd_trig != tsq_pkg::FIRST_TERM);
	wire last_ok = (wd_last <= SIMPLE_MAX);

	always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			full_q        <= 1'b0;
			run_q         <= 1'b0;
			simple_last_q <= tsq_pkg::SIMPLE_LAST_RST;
		end else begin
			if (ctrl_wr) begin
				full_q <= wd_full;
				run_q  <= wd[tsq_pkg::CTRL_RUN_BIT];
				if (last_ok)
					simple_last_q <= wd_last;
			end
			if (strig_wr & !full_q)
				simple_last_q <= tsq_pkg::FIRST_TERM;
		end
	end

	// ****************************************************************
	// Trigger term.
	// ****************************************************************
	always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
		if (!rst_sync_q)
			trig_term_q <= tsq_pkg::TRIG_TERM_RST;
		else if (spec_rst)
			trig_term_q <= tsq_pkg::TRIG_TERM_RST;
		else if (strig_wr)
			trig_term_q <= tsq_pkg::TRIG_TERM_RST;
		else if (ctrl_wr & trig_ok)
			trig_term_q <= wd_trig;
	end

	// ****************************************************************
	// Term select and interrupt mask.
	// ****************************************************************
	always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			tsel_q     <= tsq_pkg::FIRST_TERM;
			tsel_all_q <= 1'b0;
			irq_mask_q <= '0;
		end else begin
			if (tsel_wr) begin
				tsel_q     <= wd[TW-1:0];
				tsel_all_q <= wd[tsq_pkg::TSEL_ALL_BIT];
			end
			if (imr_wr)
				irq_mask_q <= wd[tsq_pkg::IRQ_W-1:0];
		end
	end

	// ****************************************************************
	// Term specification.
	// ****************************************************************
	always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			for (int i = 0; i < tsq_pkg::TERMS; i++) begin
				pri_pat_q[i]  <= (i == tsq_pkg::TERMS - 1) ? tsq_pkg::PAT_NEVER : tsq_pkg::PAT_ANY;
				sec_pat_q[i]  <= tsq_pkg::PAT_NEVER;
				sto_pat_q[i]  <= tsq_pkg::PAT_ANY;
				pri_dest_q[i] <= TW'(i + 1);
				sec_dest_q[i] <= tsq_pkg::FIRST_TERM;
			end
		end else if (spec_rst) begin
			for (int i = 0; i < tsq_pkg::TERMS; i++) begin
				pri_pat_q[i]  <= (i == tsq_pkg::TERMS - 1) ? tsq_pkg::PAT_NEVER : tsq_pkg::PAT_ANY;
				sec_pat_q[i]  <= tsq_pkg::PAT_NEVER;
				sto_pat_q[i]  <= tsq_pkg::PAT_ANY;
				pri_dest_q[i] <= TW'(i + 1);
				sec_dest_q[i] <= tsq_pkg::FIRST_TERM;
			end
		end else begin
			if (pri_wr)
				pri_pat_q[tsel_q] <= wd;
			if (sec_wr)
				sec_pat_q[tsel_q] <= wd;
			if (sto_wr) begin
				for (int i = 0; i < tsq_pkg::TERMS; i++) begin
					if (tsel_all_q | (TW'(i) == tsel_q))
						sto_pat_q[i] <= wd;
				end
			end
			if (dest_wr) begin
				pri_dest_q[tsel_q] <= wd[tsq_pkg::DEST_PRI_LSB +: TW];
				sec_dest_q[tsel_q] <= wd[tsq_pkg::DEST_SEC_LSB +: TW];
			end
			if (strig_wr) begin
				pri_pat_q[0] <= wd;
				sec_pat_q[0] <= tsq_pkg::PAT_NEVER;
				if (full_q) begin
					pri_pat_q[1] <= tsq_pkg::PAT_NEVER;
					sec_pat_q[1] <= tsq_pkg::PAT_NEVER;
				end
			end
		end
	end

	// ****************************************************************
	// Expression evaluation.
	// ****************************************************************
	tsq_eval_if ev ();

	assign ev.state   = state_i;
	assign ev.pri_pat = pri_pat_q[cur_q];
	assign ev.sec_pat = full_q ? sec_pat_q[cur_q] : sec_pat_q[0];
	assign ev.sto_pat = full_q ? sto_pat_q[cur_q] : sto_pat_q[0];

	tsq_term_eval u_eval (
		.ev (ev.eval)
	);

	// ****************************************************************
	// Sequencer.
	// ****************************************************************
	wire          step     = state_vld_i & (run_st_q == tsq_pkg::SQ_RUN);
	wire          pri      = ev.pri_hit;
	wire          sec      = ev.sec_hit & !ev.pri_hit;
	wire          last_hit = !full_q & pri & (cur_q == simple_last_q);
	wire [TW-1:0] pri_nxt  = full_q ? pri_dest_q[cur_q] : cur_q + 3'h1;
	wire [TW-1:0] sec_nxt  = full_q ? sec_dest_q[cur_q] : tsq_pkg::FIRST_TERM;
	wire [TW-1:0] nxt      = pri ? pri_nxt : sec_nxt;
	wire          branch   = step & (pri | sec) & !last_hit;
	wire          entry    = full_q & branch & (nxt == trig_term_q) & (cur_q != trig_term_q);
	wire          trig_evt = entry | (step & last_hit);
	wire          rst_evt  = step & sec;

	always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			cur_q <= tsq_pkg::FIRST_TERM;
		end else if (restart) begin
			cur_q <= tsq_pkg::FIRST_TERM;
		end else if (branch) begin
			cur_q <= nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			run_st_q <= tsq_pkg::SQ_IDLE;
		end else if (restart | !run_q) begin
			run_st_q <= tsq_pkg::SQ_IDLE;
		end else begin
			unique case (run_st_q)
				tsq_pkg::SQ_IDLE: run_st_q <= tsq_pkg::SQ_RUN;
				tsq_pkg::SQ_RUN: begin
					if (step & last_hit)
						run_st_q <= tsq_pkg::SQ_DONE;
				end
				tsq_pkg::SQ_DONE: run_st_q <= tsq_pkg::SQ_DONE;
				default: run_st_q <= tsq_pkg::SQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
		if (!rst_sync_q)
			triggered_q <= 1'b0;
		else if (trig_evt)
			triggered_q <= 1'b1;
		else if (restart)
			triggered_q <= 1'b0;
	end

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	wire active = run_q & (run_st_q != tsq_pkg::SQ_IDLE);

	always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			store_o       <= 1'b0;
			store_state_o <= '0;
			trig_o        <= 1'b0;
			term_o        <= tsq_pkg::FIRST_TERM;
		end else begin
			store_o       <= state_vld_i & active & ev.sto_hit;
			store_state_o <= state_i;
			trig_o        <= trig_evt;
			term_o        <= restart ? tsq_pkg::FIRST_TERM : (branch ? nxt : cur_q);
		end
	end

	// ****************************************************************
	// Interrupts.
	// ****************************************************************
	wire [tsq_pkg::IRQ_W-1:0] irq_set = {rst_evt, trig_evt};
	wire [tsq_pkg::IRQ_W-1:0] irq_clr = isr_wr ? wd[tsq_pkg::IRQ_W-1:0] : '0;
	wire [tsq_pkg::IRQ_W-1:0] irq_d   = (irq_stat_q & ~irq_clr) | irq_set;

	always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			irq_stat_q <= '0;
			irq_o      <= 1'b0;
		end else begin
			irq_stat_q <= irq_d;
			irq_o      <= |(irq_d & irq_mask_q);
		end
	end

endmodule // tsq_sequencer

// [test/tsq_sequencer_monitor.sv]
// Checker of the trace sequencer, bound to the top module ports.
// Assumes one clock and the asynchronous active low reset of the top module.
`timescale 1ns/100ps

module tsq_sequencer_monitor #(
	parameter int SIMPLE_TERMS = 4
) (
	input wire logic                        clk_sys_i,
	input wire logic                        rst_n_i,
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_we_i,
	input wire logic [tsq_pkg::ADR_W-1:0]   wb_adr_i,
	input wire logic [3:0]                  wb_sel_i,
	input wire logic [31:0]                 wb_dat_i,
	input wire logic [31:0]                 wb_dat_o,
	input wire logic                        wb_ack_o,
	input wire logic                        state_vld_i,
	input wire logic [tsq_pkg::STATE_W-1:0] state_i,
	input wire logic                        store_o,
	input wire logic [tsq_pkg::STATE_W-1:0] store_state_o,
	input wire logic                        trig_o,
	input wire logic [tsq_pkg::TERM_W-1:0]  term_o,
	input wire logic                        irq_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// ****************************************************************
	// Sequences and properties.
	// ****************************************************************
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_trig_pulse;
		trig_o ##1 !trig_o;
	endsequence

	property p_ack_after_req;  s_req |=> wb_ack_o; endproperty
	property p_ack_pulse;      wb_ack_o |=> !wb_ack_o; endproperty
	property p_rd_zero;        !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	property p_ack_cause;      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	property p_store_cause;
		store_o |-> $past(state_vld_i) && store_state_o == $past(state_i);
	endproperty
	property p_trig_cause;     trig_o |-> $past(state_vld_i) and s_trig_pulse; endproperty
	property p_term_cause;
		$changed(term_o) |-> $past(state_vld_i) || $past(wb_ack_o) || $past(wb_ack_o, 2);
	endproperty
	property p_irq_fall;       $fell(irq_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2); endproperty

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	a_ack_after_req: assert property (p_ack_after_req) else $error("ack missing after request");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_rd_zero: assert property (p_rd_zero) else $error("read data not zero without ack");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_store_cause: assert property (p_store_cause)
		else $error("store without state or wrong state");
	a_trig_cause: assert property (p_trig_cause)
		else $error("trigger without state or not a pulse");
	a_term_cause: assert property (p_term_cause)
		else $error("term changed without state or write");
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without register access");
endmodule // tsq_sequencer_monitor

// [test/tsq_state_src.sv]
// Model of the bus state capture front end that feeds the sequencer.
// Assumes the caller stands just after a rising clock edge.
`timescale 1ns/100ps

module tsq_state_src (
	input  wire logic                        clk_i,
	output logic                             vld_o,
	output logic      [tsq_pkg::STATE_W-1:0] state_o
);
	initial begin
		vld_o = 1'b0;
		state_o = 12'hFFF;
	end

	// Presents one state for one clock; the line then shows the inverse.
	task automatic send(input logic [tsq_pkg::STATE_W-1:0] s);
		vld_o <= 1'b1;
		state_o <= s;
		@(posedge clk_i);
		vld_o <= 1'b0;
		state_o <= ~s;
	endtask
endmodule // tsq_state_src

// [test/tb_trace_sequencer.sv]
// Self-checking bench of the trace sequencer.
// Assumes the design package, the state source model and the checker are compiled first.
`timescale 1ns/100ps

module tb_trace_sequencer;
	logic        clk_sys_i = 1'b0;
	logic        rst_n_i   = 1'b0;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat = 32'h0, dat_o, rdat;
	logic        ack, store_o, trig_o, irq_o, vld;
	logic [11:0] st, store_state_o;
	logic [2:0]  term_o;
	int          errors = 0, n_tests = 0;

	always #10 clk_sys_i = ~clk_sys_i;

	tsq_sequencer #(.SIMPLE_TERMS(4)) tsq_sequencer_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .state_vld_i(vld), .state_i(st),
		.store_o(store_o), .store_state_o(store_state_o), .trig_o(trig_o), .term_o(term_o),
		.irq_o(irq_o));
	tsq_state_src tsq_state_src_i (.clk_i(clk_sys_i), .vld_o(vld), .state_o(st));

	// ****************************************************************
	// Shared tasks.
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (ack !== 1'b1);
		chk("wb ack edges", 32'h2, k);
		rdat = dat_o;
		cyc <= 1'b0; stb <= 1'b0; sel <= 4'h0;
	endtask

	task automatic step(input logic [11:0] s, input logic [2:0] et,
			input logic es, input logic etg);
		tsq_state_src_i.send(s);
		@(posedge clk_sys_i);
		chk("term", {29'h0, et}, {29'h0, term_o});
		chk("store", {31'h0, es}, {31'h0, store_o});
		chk("trig", {31'h0, etg}, {31'h0, trig_o});
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic t_reset;
		wb(0, tsq_pkg::ADR_CTRL, 0); chk("ctrl", 32'h0000_1000, rdat);
		wb(0, tsq_pkg::ADR_STATUS, 0); chk("status", 32'h0, rdat);
		wb(1, 8'h40, 32'hFFFF_FFFF); wb(0, 8'h40, 0); chk("unmapped", 32'h0, rdat);
		wb(0, tsq_pkg::ADR_PRI_PAT, 0); chk("pri0", tsq_pkg::PAT_ANY, rdat);
		wb(1, tsq_pkg::ADR_TERM_SEL, 32'h7);
		wb(0, tsq_pkg::ADR_PRI_PAT, 0); chk("pri7", tsq_pkg::PAT_NEVER, rdat);
		$display("test reset done");
	endtask

	task automatic t_simple;
		wb(1, tsq_pkg::ADR_TERM_SEL, 32'h0);
		wb(1, tsq_pkg::ADR_SEC_PAT, 32'h8FFF_00AA);
		wb(1, tsq_pkg::ADR_STO_PAT, 32'h8FFF_00AA);
		wb(1, tsq_pkg::ADR_TERM_SEL, 32'h1);
		wb(1, tsq_pkg::ADR_PRI_PAT, 32'h8FFF_0555);
		wb(1, tsq_pkg::ADR_IRQ_MASK, 32'h3);
		wb(1, tsq_pkg::ADR_CTRL, 32'h0000_1204);
		repeat (2) @(posedge clk_sys_i);
		step(12'h123, 3'h1, 0, 0);
		step(12'h0AA, 3'h0, 1, 0);
		step(12'h0AA, 3'h1, 1, 0);
		step(12'h555, 3'h2, 0, 0);
		step(12'h321, 3'h2, 0, 1);
		wb(0, tsq_pkg::ADR_STATUS, 0); chk("status done", 32'h0000_0312, rdat);
		wb(0, tsq_pkg::ADR_IRQ_STAT, 0); chk("irq stat", 32'h3, rdat);
		chk("irq", 32'h1, {31'h0, irq_o});
		wb(1, tsq_pkg::ADR_IRQ_STAT, 32'h3);
		wb(0, tsq_pkg::ADR_IRQ_STAT, 0); chk("irq clr", 32'h0, rdat);
		chk("irq off", 32'h0, {31'h0, irq_o});
		$display("test simple done");
	endtask

	task automatic t_full;
		wb(1, tsq_pkg::ADR_CTRL, 32'h0000_1001);
		wb(1, tsq_pkg::ADR_TERM_SEL, 32'h2);
		wb(1, tsq_pkg::ADR_TERM_DEST, 32'h0000_0105);
		wb(1, tsq_pkg::ADR_SEC_PAT, 32'h8FFF_00AA);
		wb(1, tsq_pkg::ADR_PRI_PAT, 32'h8FFF_0555);
		wb(1, tsq_pkg::ADR_TERM_SEL, 32'h100);
		wb(1, tsq_pkg::ADR_STO_PAT, 32'h8FFF_0555);
		wb(1, tsq_pkg::ADR_TERM_SEL, 32'h2);
		wb(1, tsq_pkg::ADR_STO_PAT, tsq_pkg::PAT_NEVER);
		wb(1, tsq_pkg::ADR_CTRL, 32'h0000_5005);
		repeat (2) @(posedge clk_sys_i);
		step(12'h123, 3'h1, 0, 0);
		step(12'h0AA, 3'h2, 0, 0);
		step(12'h0AA, 3'h1, 0, 0);
		step(12'h0AA, 3'h2, 0, 0);
		step(12'h555, 3'h5, 0, 1);
		step(12'h555, 3'h6, 1, 0);
		step(12'h555, 3'h7, 1, 0);
		wb(1, tsq_pkg::ADR_CTRL, 32'h0000_4007);
		wb(0, tsq_pkg::ADR_PRI_PAT, 0); chk("pri2", tsq_pkg::PAT_ANY, rdat);
		wb(0, tsq_pkg::ADR_SEC_PAT, 0); chk("sec2", tsq_pkg::PAT_NEVER, rdat);
		wb(0, tsq_pkg::ADR_STO_PAT, 0); chk("sto2", tsq_pkg::PAT_ANY, rdat);
		wb(0, tsq_pkg::ADR_TERM_DEST, 0); chk("dest2", 32'h3, {29'h0, rdat[2:0]});
		wb(0, tsq_pkg::ADR_CTRL, 0); chk("trig term", 32'h1, {29'h0, rdat[14:12]});
		wb(1, tsq_pkg::ADR_SIMPLE_TRIG, 32'h8FFF_0321);
		repeat (2) @(posedge clk_sys_i);
		step(12'h123, 3'h0, 1, 0);
		step(12'h321, 3'h1, 1, 1);
		step(12'h456, 3'h1, 1, 0);
		$display("test full done");
	endtask

	initial begin
		#200000;
		errors++;
		end_sim;
	end

	initial begin
		repeat (5) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		t_reset;
		t_simple;
		t_full;
		end_sim;
	end
endmodule // tb_trace_sequencer

bind tsq_sequencer tsq_sequencer_monitor #(.SIMPLE_TERMS(SIMPLE_TERMS)) tsq_sequencer_monitor_i (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .state_vld_i(state_vld_i), .state_i(state_i),
	.store_o(store_o), .store_state_o(store_state_o), .trig_o(trig_o), .term_o(term_o),
	.irq_o(irq_o));
